// File: src/sbw_pkg.sv
package sbw_pkg;
    localparam logic [7:0] MATCH1_A   = 8'h86;
    localparam logic [7:0] MATCH1_B   = 8'h30;
    localparam logic [7:0] MATCH2_A   = 8'h79;
    localparam logic [7:0] MATCH2_B   = 8'hCF;
    localparam logic [7:0] CMD_WRITE  = 8'h30;
    localparam int         ADDR_BYTES = 3;
    localparam logic [1:0] ADDR_LAST  = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sbw_byte_t;

    typedef struct packed {
        logic        done;
        logic        ok;
        logic [15:0] sum;
    } sbw_hex_t;

    typedef enum logic [3:0] {
        SBW_M1   = 4'h0,
        SBW_M2   = 4'h1,
        SBW_CMD  = 4'h2,
        SBW_CNT  = 4'h3,
        SBW_CMP  = 4'h4,
        SBW_PASS = 4'h5,
        SBW_HEX  = 4'h6,
        SBW_SUMH = 4'h7,
        SBW_SUML = 4'h8,
        SBW_IDLE = 4'h9
    } sbw_state_t;
endpackage

// File: src/sbw_write_header.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1: Controller opens with first matching byte 0x86 or 0x30.
// RQ2: Accepted first matching byte is echoed; otherwise nothing is sent.
// RQ3: Controller then sends second matching byte 0x79 or 0xCF.
// RQ4: Controller then sends operation command 0x30 for flash write.
// RQ5: Accepted write command is echoed as 0x30; otherwise nothing is sent.
// RQ6: Password count address arrives as three bytes, high byte first.
// RQ7: Comparison start address follows as three bytes, high byte first.
// RQ8: No reply byte is sent during any address byte.
// RQ9: All bytes after adjustment use the adjusted baud rate.
// RQ10: Reserved or invalid values stop communication and idle the device.
// RQ11: Program data follows the password as binary hex records.
// RQ12: On success return checksum high then low; on error send nothing.
// RQ13: Bytes are framed start, eight data bits LSB first, one stop.
module sbw_write_header (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire sbw_pkg::sbw_byte_t rx,
    input  wire logic               tx_ready,
    input  wire logic               pass_done,
    input  wire sbw_pkg::sbw_hex_t  hex,
    output var  sbw_pkg::sbw_byte_t tx,
    output var  logic [23:0]        cnt_addr,
    output var  logic [23:0]        cmp_addr,
    output var  logic               pass_phase,
    output var  logic               hex_phase,
    output var  logic               halted
);
    import sbw_pkg::*;

    // Byte framing and baud rate live in the serial unit outside. RQ9 RQ13
    sbw_state_t  state;
    sbw_state_t  next_state;
    logic [1:0]  idx;
    logic        m1_ok;
    logic        m2_ok;
    logic        cmd_ok;

    assign m1_ok  = (rx.data == MATCH1_A) || (rx.data == MATCH1_B); // RQ1
    assign m2_ok  = (rx.data == MATCH2_A) || (rx.data == MATCH2_B); // RQ3
    assign cmd_ok = (rx.data == CMD_WRITE); // RQ4

    always_comb begin
        next_state = state;
        unique case (state)
            SBW_M1:   if (rx.valid) next_state = m1_ok ? SBW_M2 : SBW_IDLE;
            SBW_M2:   if (rx.valid) next_state = m2_ok ? SBW_CMD : SBW_IDLE;
            SBW_CMD:  if (rx.valid) next_state = cmd_ok ? SBW_CNT : SBW_IDLE;
            SBW_CNT:  if (rx.valid && idx == ADDR_LAST) next_state = SBW_CMP;
            SBW_CMP:  if (rx.valid && idx == ADDR_LAST) next_state = SBW_PASS;
            SBW_PASS: if (pass_done) next_state = SBW_HEX; // RQ11
            SBW_HEX:  if (hex.done) next_state = hex.ok ? SBW_SUMH : SBW_IDLE;
            SBW_SUMH: if (tx_ready) next_state = SBW_SUML;
            SBW_SUML: if (tx_ready) next_state = SBW_IDLE;
            SBW_IDLE: next_state = SBW_IDLE; // RQ10
            default:  next_state = SBW_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state <= SBW_M1;
        end else begin
            state <= next_state;
        end
    end

    // Byte index within an address group
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            idx <= 2'h0;
        end else if ((state == SBW_CNT || state == SBW_CMP) && rx.valid) begin
            idx <= (idx == ADDR_LAST) ? 2'h0 : idx + 2'h1;
        end
    end

    // Shift in addresses MSB first, silently. RQ6 RQ7 RQ8
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt_addr <= 24'h0;
            cmp_addr <= 24'h0;
        end else if (rx.valid && state == SBW_CNT) begin
            cnt_addr <= {cnt_addr[15:0], rx.data}; // RQ6
        end else if (rx.valid && state == SBW_CMP) begin
            cmp_addr <= {cmp_addr[15:0], rx.data}; // RQ7
        end
    end

    // Transmit: echoes and checksum only; a held byte waits for tx_ready
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx <= '0;
        end else if (tx.valid && !tx_ready) begin
            // Hold wins, so a stalled echo is never overwritten
            tx <= tx;
        end else if (state == SBW_M1 && rx.valid && m1_ok) begin
            tx <= '{valid: 1'b1, data: rx.data}; // RQ2
        end else if (state == SBW_CMD && rx.valid && cmd_ok) begin
            tx <= '{valid: 1'b1, data: CMD_WRITE}; // RQ5
        end else if (state == SBW_HEX && hex.done && hex.ok) begin
            tx <= '{valid: 1'b1, data: hex.sum[15:8]}; // RQ12
        end else if (state == SBW_SUMH && tx_ready) begin
            tx <= '{valid: 1'b1, data: hex.sum[7:0]}; // RQ12
        end else begin
            tx <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pass_phase <= 1'b0;
            hex_phase  <= 1'b0;
            halted     <= 1'b0;
        end else begin
            pass_phase <= (next_state == SBW_PASS);
            hex_phase  <= (next_state == SBW_HEX);
            halted     <= (next_state == SBW_IDLE); // RQ10
        end
    end

    property p_echo1;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_M1 && rx.valid && m1_ok && !tx.valid
        |=> tx.valid && tx.data == $past(rx.data);
    endproperty
    a_echo1: assert property (p_echo1) // RQ2
        else $error("first match not echoed");

    property p_noecho;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_M1 && rx.valid && !m1_ok
        |=> state == SBW_IDLE && !tx.valid;
    endproperty
    a_noecho: assert property (p_noecho) // RQ2 RQ10
        else $error("bad match did not idle");

    property p_cmd;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_CMD && rx.valid && cmd_ok && !tx.valid
        |=> tx.valid && tx.data == CMD_WRITE;
    endproperty
    a_cmd: assert property (p_cmd) // RQ5
        else $error("command echo wrong");

    // The command echo may still stand here; only a new byte is wrong
    property p_silent;
        @(posedge core_clk) disable iff (!rst_b)
        (state == SBW_CNT || state == SBW_CMP) && !tx.valid
        |=> !tx.valid;
    endproperty
    a_silent: assert property (p_silent) // RQ8
        else $error("reply during address");

    property p_idle;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_IDLE && !tx.valid
        |=> !tx.valid [*3];
    endproperty
    a_idle: assert property (p_idle) // RQ10
        else $error("traffic while idle");

    property p_sum;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_HEX && hex.done && !hex.ok
        |=> !tx.valid;
    endproperty
    a_sum: assert property (p_sum) // RQ12
        else $error("checksum on error");

    property p_addr;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_CNT && rx.valid
        |=> cnt_addr[7:0] == $past(rx.data);
    endproperty
    a_addr: assert property (p_addr) // RQ6
        else $error("count address shift wrong");

    property p_cmp;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_CMP && rx.valid
        |=> cmp_addr[7:0] == $past(rx.data);
    endproperty
    a_cmp: assert property (p_cmp) // RQ7
        else $error("compare address shift wrong");

    property p_sumh;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_HEX && hex.done && hex.ok && !tx.valid
        |=> tx.valid && tx.data == $past(hex.sum[15:8]);
    endproperty
    a_sumh: assert property (p_sumh) // RQ12
        else $error("checksum high byte wrong");

    property p_suml;
        @(posedge core_clk) disable iff (!rst_b)
        state == SBW_SUMH && tx_ready
        |=> tx.valid && tx.data == $past(hex.sum[7:0]);
    endproperty
    a_suml: assert property (p_suml) // RQ12
        else $error("checksum low byte wrong");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_b)
        tx.valid && !tx_ready |=> $stable(tx);
    endproperty
    a_hold: assert property (p_hold) // RQ12
        else $error("reply byte dropped before taken");

    property p_halted;
        @(posedge core_clk) disable iff (!rst_b)
        halted == (state == SBW_IDLE);
    endproperty
    a_halted: assert property (p_halted) // RQ10
        else $error("halt flag out of step");

    property p_phase;
        @(posedge core_clk) disable iff (!rst_b)
        pass_phase == (state == SBW_PASS)
        && hex_phase == (state == SBW_HEX);
    endproperty
    a_phase: assert property (p_phase) // RQ11
        else $error("phase flags out of step");

    // Main scenarios
    c_pass: cover property (@(posedge core_clk) state == SBW_PASS);
    c_sum:  cover property (@(posedge core_clk) state == SBW_SUML);
    c_bad:  cover property (@(posedge core_clk)
        state == SBW_CMD ##1 state == SBW_IDLE);
    c_stall: cover property (@(posedge core_clk)
        (tx.valid && !tx_ready) [*3]);
endmodule
`default_nettype wire

// File: sim/sbw_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbw_ctrl_model (
    input  wire logic               core_clk,
    input  wire logic               slow,
    input  wire sbw_pkg::sbw_byte_t tx,
    output var  logic               tx_ready
);
    import sbw_pkg::*;
    logic [7:0] log[$];
    int         wait_n;
    initial tx_ready = 1'b0;
    initial wait_n = 0;
    // Slow mode stalls each byte, as a busy controller would
    always @(posedge core_clk) begin
        if (tx.valid && tx_ready) log.push_back(tx.data);
        wait_n <= (tx.valid && !tx_ready) ? wait_n + 1 : 0;
        tx_ready <= tx.valid && !tx_ready && (!slow || wait_n >= 3);
    end
endmodule
`default_nettype wire

// File: sim/serial_boot_flash_write_header_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_boot_flash_write_header_test;
    import sbw_pkg::*;
    logic        core_clk, rst_b, tx_ready, pass_done, slow;
    logic        pass_phase, hex_phase, halted;
    logic [23:0] cnt_addr, cmp_addr;
    sbw_byte_t   rx, tx;
    sbw_hex_t    hex;
    int          failures, compares, cyc;
    sbw_write_header i_sbw_write_header (.core_clk(core_clk),
        .rst_b(rst_b), .rx(rx), .tx_ready(tx_ready),
        .pass_done(pass_done), .hex(hex), .tx(tx), .cnt_addr(cnt_addr),
        .cmp_addr(cmp_addr), .pass_phase(pass_phase),
        .hex_phase(hex_phase), .halted(halted));
    sbw_ctrl_model i_sbw_ctrl_model (.core_clk(core_clk), .slow(slow),
        .tx(tx), .tx_ready(tx_ready));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            close_out();
        end
    end
    task close_out();
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task check(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task reset();
        rst_b <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        i_sbw_ctrl_model.log.delete();
    endtask
    // Long gap keeps each echo clear of the next byte
    task put(input logic [7:0] b);
        rx <= '{1'b1, b};
        @(posedge core_clk);
        rx <= '{1'b0, ~b};
        repeat (12) @(posedge core_clk);
    endtask
    function logic log_is(input int n, input logic [7:0] a, b, c, d);
        logic [7:0] e[4];
        e = '{a, b, c, d};
        if (i_sbw_ctrl_model.log.size() != n) return 1'b0;
        for (int i = 0; i < n; i++)
            if (i_sbw_ctrl_model.log[i] !== e[i]) return 1'b0;
        return 1'b1;
    endfunction
    task session(input logic [7:0] m1, m2, input logic ok,
                 input logic [15:0] s);
        reset();
        put(m1);
        put(m2);
        put(CMD_WRITE);
        for (int i = 0; i < 2 * ADDR_BYTES; i++)
            put(8'(8'h11 * (i + 1)));
        check(cnt_addr === 24'h112233, "cnt addr");
        check(cmp_addr === 24'h445566, "cmp addr");
        check(log_is(2, m1, CMD_WRITE, 0, 0), "echo");
        check(pass_phase === 1'b1, "pass phase");
        pass_done <= 1'b1;
        @(posedge core_clk);
        pass_done <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(hex_phase === 1'b1, "hex phase");
        hex <= '{1'b1, ok, s};
        @(posedge core_clk);
        hex <= '{1'b0, ok, s};
        repeat (20) @(posedge core_clk);
        check(ok ? log_is(4, m1, CMD_WRITE, s[15:8], s[7:0])
                 : log_is(2, m1, CMD_WRITE, 0, 0), "sum");
        check(halted === 1'b1, "halt");
    endtask
    task refuse(input logic [7:0] m1, m2, c, input int n);
        reset();
        put(m1);
        put(m2);
        put(c);
        put(MATCH1_A);
        check(log_is(n, m1, 0, 0, 0), "silent");
        check(halted === 1'b1, "halt");
    endtask
    initial begin
        rst_b = 1'b0;
        rx = '0;
        pass_done = 1'b0;
        hex = '0;
        slow = 1'b0;
        failures = 0;
        compares = 0;
        cyc = 0;
        session(MATCH1_A, MATCH2_A, 1'b1, 16'hA55A);
        slow <= 1'b1;
        session(MATCH1_B, MATCH2_B, 1'b1, 16'h0FF0);
        session(MATCH1_A, MATCH2_B, 1'b0, 16'h1234);
        refuse(8'h87, MATCH2_A, CMD_WRITE, 0);
        refuse(MATCH1_A, 8'h78, CMD_WRITE, 1);
        refuse(MATCH1_B, MATCH2_A, 8'h31, 1);
        close_out();
    end
endmodule
`default_nettype wire
